// ===== inc/bts_pkg.sv
// shared constants, register map and state types of the breaker sequencer
package bts_pkg;

  // ****************************************
  // time base
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_PERIOD_NS = 100_000_000; // 0.1 s
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // ****************************************
  // timer settings, counted in 0.1 s ticks
  // ****************************************
  localparam int TW = 16;
  localparam logic [TW-1:0] PULSE_DEF = 16'h0005; // 0.5 s
  localparam logic [TW-1:0] FAIL_DEF = 16'h0014;  // 2.0 s
  localparam logic [TW-1:0] PULSE_MAX = 16'h0064; // 10 s
  localparam logic [TW-1:0] DEAD_DEF = 16'h0005;  // 0.5 s
  localparam logic [TW-1:0] DEAD_MAX = 16'h1770;  // 600 s
  localparam logic [TW-1:0] DEC = 16'h0001;
  localparam int NTMR = 10;
  localparam int T_M_HOLD = 0;
  localparam int T_M_CLOSE = 1;
  localparam int T_M_OPEN = 2;
  localparam int T_M_FAIL = 3;
  localparam int T_G_HOLD = 4;
  localparam int T_G_CLOSE = 5;
  localparam int T_G_OPEN = 6;
  localparam int T_G_FAIL = 7;
  localparam int T_G_DEAD = 8; // mains dropped, genset contactor waits
  localparam int T_M_DEAD = 9; // genset dropped, mains contactor waits
  localparam logic [NTMR-1:0][TW-1:0] TMR_RST = {DEAD_DEF, DEAD_DEF,
    FAIL_DEF, PULSE_DEF, PULSE_DEF, PULSE_DEF,
    FAIL_DEF, PULSE_DEF, PULSE_DEF, PULSE_DEF};

  // ****************************************
  // register map
  // ****************************************
  localparam int AW = 8;
  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_STATUS = 8'h04;
  localparam logic [AW-1:0] A_INT_ST = 8'h08;
  localparam logic [AW-1:0] A_INT_MASK = 8'h0C;
  localparam logic [AW-1:0] A_TMR_BASE = 8'h10;
  localparam logic [AW-1:0] A_STEP = 8'h04;
  localparam int CTRL_W = 6;
  localparam int C_LOAD_EN = 0;
  localparam int C_SEL_GEN = 1;
  localparam int C_M_PHASE = 2;
  localparam int C_G_PHASE = 3;
  localparam int C_M_FB = 4;
  localparam int C_G_FB = 5;
  localparam int IRQ_W = 5;
  localparam int I_M_FAIL = 0;
  localparam int I_G_FAIL = 1;
  localparam int I_M_PHASE = 2;
  localparam int I_G_PHASE = 3;
  localparam int I_XFER = 4;

  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [2:0] {
    BRK_OPEN_ST, BRK_HOLD, BRK_CLOSE, BRK_CLOSED, BRK_OPEN
  } brk_state_t;
  typedef enum logic [2:0] {
    XF_OFF, XF_MAINS, XF_DEAD_G, XF_GEN, XF_DEAD_M
  } xfer_state_t;

  // limit a written timer value to its largest legal setting
  function automatic logic [TW-1:0] clamp(input logic [TW-1:0] v,
                                          input logic [TW-1:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction : clamp

endpackage : bts_pkg

// ===== core/tick_gen.sv
// common 0.1 s tick generator
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
  parameter int TICK_CYCLES = bts_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  output logic tick
);
  localparam int CW = $clog2(TICK_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
  localparam logic [CW-1:0] STEP = CW'(1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } tick_state_t;

  tick_state_t s_reg, s_next;

  // one pulse every TICK_CYCLES clocks
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt == LAST) begin
      s_next.cnt = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + STEP;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;
endmodule : tick_gen
`default_nettype wire

// ===== core/breaker_ctrl.sv
// one motorized breaker: hold coil, close and open pulses, fail watch
`timescale 1ns/1ps
`default_nettype none
module breaker_ctrl (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic close_req,
  input wire logic open_req,
  input wire logic fb_en,
  input wire logic fb_closed,
  input wire logic [bts_pkg::TW-1:0] hold_ticks,
  input wire logic [bts_pkg::TW-1:0] close_ticks,
  input wire logic [bts_pkg::TW-1:0] open_ticks,
  input wire logic [bts_pkg::TW-1:0] fail_ticks,
  output logic breaker_hold_coil_output,
  output logic breaker_close_output,
  output logic breaker_open_output,
  output logic fail_pulse
);
  typedef struct packed {
    bts_pkg::brk_state_t st;
    logic [bts_pkg::TW-1:0] cnt;
    logic [bts_pkg::TW-1:0] fcnt;
    logic fwatch;
    logic target;
    logic hold;
    logic cls;
    logic opn;
    logic fail;
  } brk_reg_t;

  brk_reg_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.fail = 1'b0;
    // position watch: feedback must match target when the timer ends
    if (s_reg.fwatch) begin
      if (s_reg.fcnt == '0) begin
        s_next.fwatch = 1'b0;
        s_next.fail = (fb_closed != s_reg.target);
      end else if (tick) begin
        s_next.fcnt = s_reg.fcnt - bts_pkg::DEC;
      end
    end
    // an open request aborts any close in progress
    if (open_req && s_reg.st != bts_pkg::BRK_OPEN_ST
        && s_reg.st != bts_pkg::BRK_OPEN) begin
      s_next.st = bts_pkg::BRK_OPEN;
      s_next.cnt = open_ticks;
      s_next.hold = 1'b0;
      s_next.cls = 1'b0;
      s_next.opn = 1'b1;
      s_next.fwatch = fb_en;
      s_next.fcnt = fail_ticks;
      s_next.target = 1'b0;
    end else begin
      case (s_reg.st)
        bts_pkg::BRK_OPEN_ST: begin
          if (close_req) begin
            s_next.st = bts_pkg::BRK_HOLD;
            s_next.cnt = hold_ticks;
            s_next.hold = 1'b1;
          end
        end
        bts_pkg::BRK_HOLD: begin
          if (s_reg.cnt == '0) begin
            s_next.st = bts_pkg::BRK_CLOSE;
            s_next.cnt = close_ticks;
            s_next.cls = 1'b1;
            s_next.fwatch = fb_en;
            s_next.fcnt = fail_ticks;
            s_next.target = 1'b1;
          end else if (tick) begin
            s_next.cnt = s_reg.cnt - bts_pkg::DEC;
          end
        end
        bts_pkg::BRK_CLOSE: begin
          if (s_reg.cnt == '0) begin
            s_next.st = bts_pkg::BRK_CLOSED;
            s_next.cls = 1'b0;
          end else if (tick) begin
            s_next.cnt = s_reg.cnt - bts_pkg::DEC;
          end
        end
        bts_pkg::BRK_OPEN: begin
          if (s_reg.cnt == '0) begin
            s_next.st = bts_pkg::BRK_OPEN_ST;
            s_next.opn = 1'b0;
          end else if (tick) begin
            s_next.cnt = s_reg.cnt - bts_pkg::DEC;
          end
        end
        default: begin
          s_next.st = s_reg.st; // closed: hold coil stays energized
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign breaker_hold_coil_output = s_reg.hold;
  assign breaker_close_output = s_reg.cls;
  assign breaker_open_output = s_reg.opn;
  assign fail_pulse = s_reg.fail;
endmodule : breaker_ctrl
`default_nettype wire

// ===== core/breaker_transfer_sequencer.sv
// mains/genset transfer sequencer with registers, interrupt and breakers
`timescale 1ns/1ps
`default_nettype none
module breaker_transfer_sequencer #(
  parameter int TICK_CYCLES = bts_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [bts_pkg::AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire logic mains_fb_closed,
  input wire logic genset_fb_closed,
  input wire logic mains_phase_bad,
  input wire logic genset_phase_bad,
  output logic mains_breaker_hold_coil_output,
  output logic mains_breaker_close_output,
  output logic mains_breaker_open_output,
  output logic genset_breaker_hold_coil_output,
  output logic genset_breaker_close_output,
  output logic genset_breaker_open_output,
  output logic mains_contactor,
  output logic genset_contactor,
  output logic irq
);
  typedef struct packed {
    logic [bts_pkg::CTRL_W-1:0] ctrl;
    logic [bts_pkg::NTMR-1:0][bts_pkg::TW-1:0] tmr;
    logic [bts_pkg::IRQ_W-1:0] int_st;
    logic [bts_pkg::IRQ_W-1:0] int_mask;
    bts_pkg::xfer_state_t xs;
    logic [bts_pkg::TW-1:0] cnt;
    logic mfb1, mfb2, gfb1, gfb2;
    logic mph1, mph2, gph1, gph2;
    logic m_close_req, m_open_req, g_close_req, g_open_req;
    logic mc, gc, irq;
    logic [31:0] rdata;
  } top_reg_t;

  top_reg_t s_reg, s_next;
  logic tick;
  logic m_fail, g_fail;
  logic m_hold, m_cls, m_opn, g_hold, g_cls, g_opn;

  // ****************************************
  // time base and breakers
  // ****************************************
  tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .tick(tick)
  );

  breaker_ctrl u_mains (
    .clk(clk),
    .arst_n(arst_n),
    .tick(tick),
    .close_req(s_reg.m_close_req),
    .open_req(s_reg.m_open_req),
    .fb_en(s_reg.ctrl[bts_pkg::C_M_FB]),
    .fb_closed(s_reg.mfb2),
    .hold_ticks(s_reg.tmr[bts_pkg::T_M_HOLD]),
    .close_ticks(s_reg.tmr[bts_pkg::T_M_CLOSE]),
    .open_ticks(s_reg.tmr[bts_pkg::T_M_OPEN]),
    .fail_ticks(s_reg.tmr[bts_pkg::T_M_FAIL]),
    .breaker_hold_coil_output(m_hold),
    .breaker_close_output(m_cls),
    .breaker_open_output(m_opn),
    .fail_pulse(m_fail)
  );

  breaker_ctrl u_genset (
    .clk(clk),
    .arst_n(arst_n),
    .tick(tick),
    .close_req(s_reg.g_close_req),
    .open_req(s_reg.g_open_req),
    .fb_en(s_reg.ctrl[bts_pkg::C_G_FB]),
    .fb_closed(s_reg.gfb2),
    .hold_ticks(s_reg.tmr[bts_pkg::T_G_HOLD]),
    .close_ticks(s_reg.tmr[bts_pkg::T_G_CLOSE]),
    .open_ticks(s_reg.tmr[bts_pkg::T_G_OPEN]),
    .fail_ticks(s_reg.tmr[bts_pkg::T_G_FAIL]),
    .breaker_hold_coil_output(g_hold),
    .breaker_close_output(g_cls),
    .breaker_open_output(g_opn),
    .fail_pulse(g_fail)
  );

  // ****************************************
  // sequencer, registers and interrupt
  // ****************************************
  always_comb begin
    logic want_m;
    logic want_g;
    logic m_bad;
    logic [bts_pkg::IRQ_W-1:0] set;
    logic [bts_pkg::IRQ_W-1:0] clr;
    logic [bts_pkg::AW-1:0] ta;
    s_next = s_reg;
    want_m = s_reg.ctrl[bts_pkg::C_LOAD_EN] & ~s_reg.ctrl[bts_pkg::C_SEL_GEN];
    want_g = s_reg.ctrl[bts_pkg::C_LOAD_EN] & s_reg.ctrl[bts_pkg::C_SEL_GEN];
    m_bad = s_reg.ctrl[bts_pkg::C_M_PHASE] & s_reg.mph2;
    set = '0;
    clr = '0;
    ta = bts_pkg::A_TMR_BASE;
    // pin inputs pass two flops before use
    s_next.mfb1 = mains_fb_closed;
    s_next.mfb2 = s_reg.mfb1;
    s_next.gfb1 = genset_fb_closed;
    s_next.gfb2 = s_reg.gfb1;
    s_next.mph1 = mains_phase_bad;
    s_next.mph2 = s_reg.mph1;
    s_next.gph1 = genset_phase_bad;
    s_next.gph2 = s_reg.gph1;
    s_next.m_close_req = 1'b0;
    s_next.m_open_req = 1'b0;
    s_next.g_close_req = 1'b0;
    s_next.g_open_req = 1'b0;

    // transfer: never both contactors, dead time in between
    case (s_reg.xs)
      bts_pkg::XF_OFF: begin
        if (want_m) begin
          s_next.xs = bts_pkg::XF_DEAD_M;
          s_next.cnt = s_reg.tmr[bts_pkg::T_M_DEAD];
        end else if (want_g) begin
          s_next.xs = bts_pkg::XF_DEAD_G;
          s_next.cnt = s_reg.tmr[bts_pkg::T_G_DEAD];
        end
      end
      bts_pkg::XF_MAINS: begin
        if (!want_m) begin
          s_next.m_open_req = 1'b1;
          s_next.xs = want_g ? bts_pkg::XF_DEAD_G : bts_pkg::XF_OFF;
          s_next.cnt = s_reg.tmr[bts_pkg::T_G_DEAD];
        end
      end
      bts_pkg::XF_DEAD_G: begin
        if (!want_g) begin
          s_next.xs = bts_pkg::XF_OFF;
        end else if (s_reg.cnt == '0) begin
          s_next.xs = bts_pkg::XF_GEN;
          s_next.g_close_req = 1'b1;
          set[bts_pkg::I_XFER] = 1'b1;
        end else if (tick) begin
          s_next.cnt = s_reg.cnt - bts_pkg::DEC;
        end
      end
      bts_pkg::XF_GEN: begin
        if (!want_g) begin
          s_next.g_open_req = 1'b1;
          s_next.xs = want_m ? bts_pkg::XF_DEAD_M : bts_pkg::XF_OFF;
          s_next.cnt = s_reg.tmr[bts_pkg::T_M_DEAD];
        end
      end
      default: begin
        if (!want_m) begin
          s_next.xs = bts_pkg::XF_OFF;
        end else if (s_reg.cnt == '0) begin
          s_next.xs = bts_pkg::XF_MAINS;
          s_next.m_close_req = 1'b1;
          set[bts_pkg::I_XFER] = 1'b1;
        end else if (tick) begin
          s_next.cnt = s_reg.cnt - bts_pkg::DEC;
        end
      end
    endcase
    // a bad mains phase order drops the mains contactor at once
    s_next.mc = (s_next.xs == bts_pkg::XF_MAINS) && !m_bad;
    s_next.gc = (s_next.xs == bts_pkg::XF_GEN);

    // events
    set[bts_pkg::I_M_FAIL] = m_fail;
    set[bts_pkg::I_G_FAIL] = g_fail;
    set[bts_pkg::I_M_PHASE] = m_bad;
    set[bts_pkg::I_G_PHASE] =
      s_reg.ctrl[bts_pkg::C_G_PHASE] & s_reg.gph2;

    // register writes; timer values clamp to their legal range
    if (wr_stb) begin
      if (addr == bts_pkg::A_CTRL) begin
        s_next.ctrl = wdata[bts_pkg::CTRL_W-1:0];
      end else if (addr == bts_pkg::A_INT_ST) begin
        clr = wdata[bts_pkg::IRQ_W-1:0];
      end else if (addr == bts_pkg::A_INT_MASK) begin
        s_next.int_mask = wdata[bts_pkg::IRQ_W-1:0];
      end else begin
        for (int i = 0; i < bts_pkg::NTMR; i++) begin
          if (addr == ta) begin
            s_next.tmr[i] = bts_pkg::clamp(wdata[bts_pkg::TW-1:0],
              (i >= bts_pkg::T_G_DEAD) ? bts_pkg::DEAD_MAX
                                       : bts_pkg::PULSE_MAX);
          end
          ta = ta + bts_pkg::A_STEP;
        end
      end
    end
    // set wins over a write-one clear in the same cycle
    s_next.int_st = (s_reg.int_st & ~clr) | set;
    s_next.irq = |(s_next.int_st & s_next.int_mask);

    // read data stand for one cycle only
    s_next.rdata = '0;
    ta = bts_pkg::A_TMR_BASE;
    if (rd_stb) begin
      if (addr == bts_pkg::A_CTRL) begin
        s_next.rdata = 32'(s_reg.ctrl);
      end else if (addr == bts_pkg::A_STATUS) begin
        s_next.rdata = 32'({s_reg.xs, s_reg.gfb2, s_reg.mfb2,
          s_reg.gc, s_reg.mc, g_opn, g_cls, g_hold,
          m_opn, m_cls, m_hold});
      end else if (addr == bts_pkg::A_INT_ST) begin
        s_next.rdata = 32'(s_reg.int_st);
      end else if (addr == bts_pkg::A_INT_MASK) begin
        s_next.rdata = 32'(s_reg.int_mask);
      end else begin
        for (int i = 0; i < bts_pkg::NTMR; i++) begin
          if (addr == ta) begin
            s_next.rdata = 32'(s_reg.tmr[i]);
          end
          ta = ta + bts_pkg::A_STEP;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
      s_reg.tmr <= bts_pkg::TMR_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign mains_contactor = s_reg.mc;
  assign genset_contactor = s_reg.gc;
  assign irq = s_reg.irq;
  assign mains_breaker_hold_coil_output = m_hold;
  assign mains_breaker_close_output = m_cls;
  assign mains_breaker_open_output = m_opn;
  assign genset_breaker_hold_coil_output = g_hold;
  assign genset_breaker_close_output = g_cls;
  assign genset_breaker_open_output = g_opn;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_m_hold_first: assert property (
    $rose(m_cls) |-> m_hold && $past(m_hold))
    else $error("mains close without hold coil");
  chk_m_close_coil: assert property (m_cls |-> m_hold)
    else $error("mains close while coil off");
  chk_m_open_excl: assert property (
    m_opn |-> !m_cls && !m_hold)
    else $error("mains open overlaps close");
  chk_m_fault_flag: assert property (
    m_fail |=> s_reg.int_st[bts_pkg::I_M_FAIL])
    else $error("mains fault not flagged");
  chk_m_phase_drop: assert property (
    s_reg.ctrl[bts_pkg::C_M_PHASE] && s_reg.mph2 |=> !mains_contactor)
    else $error("mains contactor kept on bad phase");
  chk_contactor_excl: assert property (
    $rose(genset_contactor) |-> !mains_contactor && $past(!mains_contactor))
    else $error("contactors overlap");
  chk_g_hold_first: assert property (
    $rose(g_cls) |-> g_hold && $past(g_hold))
    else $error("genset close without hold coil");
  chk_g_close_coil: assert property (g_cls |-> g_hold)
    else $error("genset close while coil off");
  chk_g_open_excl: assert property (
    g_opn |-> !g_cls && !g_hold)
    else $error("genset open overlaps close");
  chk_g_fault_flag: assert property (
    g_fail |=> s_reg.int_st[bts_pkg::I_G_FAIL])
    else $error("genset fault not flagged");
  chk_g_phase_alarm: assert property (
    s_reg.ctrl[bts_pkg::C_G_PHASE] && s_reg.gph2
    |=> s_reg.int_st[bts_pkg::I_G_PHASE])
    else $error("genset phase alarm missing");
  chk_m_after_gen: assert property (
    $rose(mains_contactor) |-> !genset_contactor)
    else $error("mains on while genset on");
  chk_tick_single: assert property (tick |=> !tick)
    else $error("tick longer than one cycle");

  cov_to_genset: cover property ($rose(genset_contactor));
  cov_to_mains: cover property ($rose(mains_contactor));
  cov_m_fault: cover property (m_fail);
  cov_irq: cover property ($rose(irq));
endmodule : breaker_transfer_sequencer
`default_nettype wire

// ===== testbench/breaker_model.sv
// behavioural relay-driven breaker that reports its position
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// breaker mechanism model
// ****************************************
module breaker_model #(
  parameter int DLY = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic close_out,
  input wire logic open_out,
  input wire logic stuck,
  output logic fb_closed
);
  int cnt;
  logic tgt;
  // the contacts move DLY cycles after the coil pulse ends; a stuck
  // mechanism ignores both relays, which is how a fault is provoked
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      tgt <= 1'b0;
      fb_closed <= 1'b0;
    end else if (!stuck && (close_out || open_out)) begin
      tgt <= close_out;
      cnt <= DLY;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      fb_closed <= tgt;
    end
  end
endmodule : breaker_model
`default_nettype wire

// ===== testbench/breaker_transfer_sequencer_tb.sv
// self-checking testbench of the breaker transfer sequencer
`timescale 1ns/1ps
`default_nettype none
module breaker_transfer_sequencer_tb;
  // short tick keeps every programmed period a few dozen cycles
  localparam int T = 8;
  localparam int LIM = 3000;
  logic clk = 1'b0, arst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic mfb, gfb, mbad = 1'b0, gbad = 1'b0, mstk = 1'b0, gstk = 1'b0;
  wire [8:0] o;
  int errors = 0, n_compared = 0, cyc = 0, sd, tv[10];
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  breaker_transfer_sequencer #(.TICK_CYCLES(T)) dut_u (.clk(clk),
    .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .mains_fb_closed(mfb),
    .genset_fb_closed(gfb), .mains_phase_bad(mbad),
    .genset_phase_bad(gbad), .mains_breaker_hold_coil_output(o[0]),
    .mains_breaker_close_output(o[1]), .mains_breaker_open_output(o[2]),
    .genset_breaker_hold_coil_output(o[3]),
    .genset_breaker_close_output(o[4]), .genset_breaker_open_output(o[5]),
    .mains_contactor(o[6]), .genset_contactor(o[7]), .irq(o[8]));
  // mains answers promptly, genset slowly
  breaker_model #(.DLY(2)) mb_u (.clk(clk), .arst_n(arst_n),
    .close_out(o[1]), .open_out(o[2]), .stuck(mstk), .fb_closed(mfb));
  breaker_model #(.DLY(10)) gb_u (.clk(clk), .arst_n(arst_n),
    .close_out(o[4]), .open_out(o[5]), .stuck(gstk), .fb_closed(gfb));
  // ****************************************
  // bus, wait and compare tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic wrap_up;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic chk_eq(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_eq
  // a period of n ticks lasts n ticks less up to one tick of phase
  task automatic chk_win(input int g, input int n);
    n_compared++;
    if (g < (n - 1) * T || g > (n + 1) * T + 3) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, n * T);
    end
  endtask : chk_win
  task automatic wt(input int i, input logic v);
    int k;
    k = 0;
    #1;
    while (o[i] !== v && k < LIM) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= LIM) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, o[i], v);
      wrap_up();
    end
  endtask : wt
  // hold coil, then close pulse, then, when flt is set, the fail watch raising irq
  task automatic close_seq(input int ob, input int tb, input bit flt);
    int s;
    wt(ob, 1'b1);
    s = cyc;
    wt(ob + 1, 1'b1);
    chk_win(cyc - s, tv[tb]);
    s = cyc;
    wt(ob + 1, 1'b0);
    chk_win(cyc - s, tv[tb + 1]);
    if (flt) begin
      wt(8, 1'b1);
      chk_win(cyc - s, tv[tb + 3]);
    end
  endtask : close_seq
  // open pulse of the leaving side, then the dead time of the other
  task automatic swap(input logic [31:0] c, input int oc, input int ob,
                      input int tb, input int dk);
    int s;
    wr(bts_pkg::A_CTRL, c);
    wt(oc, 1'b0);
    sd = cyc;
    wt(ob, 1'b1);
    s = cyc;
    wt(ob, 1'b0);
    chk_win(cyc - s, tv[tb]);
    wt(13 - oc, 1'b1);
    chk_win(cyc - sd, tv[dk]);
    chk_eq({31'h0, o[oc]}, 32'h0);
  endtask : swap
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h28D40D89));
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd(bts_pkg::A_TMR_BASE + 8'(i * 4));
      chk_eq(d, 32'(bts_pkg::TMR_RST[i]));
    end
    rd(bts_pkg::A_CTRL);
    chk_eq(d, 32'h0);
    rd(8'h40);
    chk_eq(d, 32'h0);
    // out-of-range settings clamp to the largest legal period
    wr(bts_pkg::A_TMR_BASE + 8'h04, 32'h0000FFFF);
    rd(bts_pkg::A_TMR_BASE + 8'h04);
    chk_eq(d, 32'(bts_pkg::PULSE_MAX));
    wr(bts_pkg::A_TMR_BASE + 8'h20, 32'h0000FFFF);
    rd(bts_pkg::A_TMR_BASE + 8'h20);
    chk_eq(d, 32'(bts_pkg::DEAD_MAX));
    // dead times outlast any open pulse so the stamps stay ordered
    for (int i = 0; i < 10; i++) begin
      tv[i] = (i == 3 || i == 7) ? 12 : (i > 7) ? 6 + $urandom % 3 :
              1 + $urandom % 3;
      wr(bts_pkg::A_TMR_BASE + 8'(i * 4), 32'(tv[i]));
    end
    wr(bts_pkg::A_INT_MASK, 32'h00000003);
    sd = cyc;
    wr(bts_pkg::A_CTRL, 32'h00000031);
    wt(6, 1'b1);
    chk_win(cyc - sd, tv[9]);
    close_seq(0, 0, 1'b0);
    repeat (14 * T) @(posedge clk);
    rd(bts_pkg::A_INT_ST);
    chk_eq(d, 32'h00000010);
    chk_eq({31'h0, o[8]}, 32'h0);
    wr(bts_pkg::A_INT_ST, 32'h0000001F);
    gstk <= 1'b1;
    swap(32'h00000033, 6, 2, 2, 8);
    close_seq(3, 4, 1'b1);
    rd(bts_pkg::A_INT_ST);
    chk_eq(d & 32'h00000013, 32'h00000012);
    wr(bts_pkg::A_INT_ST, 32'h0000001F);
    mstk <= 1'b1;
    swap(32'h00000031, 7, 5, 6, 9);
    close_seq(0, 0, 1'b1);
    rd(bts_pkg::A_INT_ST);
    chk_eq(d & 32'h00000003, 32'h00000001);
    wr(bts_pkg::A_INT_ST, 32'h0000001F);
    rd(bts_pkg::A_INT_ST);
    chk_eq(d, 32'h0);
    chk_eq({31'h0, o[8]}, 32'h0);
    // bad phase order is ignored while both checks are off
    wr(bts_pkg::A_INT_MASK, 32'h0000000C);
    mbad <= 1'b1;
    gbad <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk_eq({31'h0, o[6]}, 32'h1);
    chk_eq({31'h0, o[8]}, 32'h0);
    wr(bts_pkg::A_CTRL, 32'h0000003D);
    wt(6, 1'b0);
    rd(bts_pkg::A_INT_ST);
    chk_eq(d & 32'h0000000C, 32'h0000000C);
    chk_eq({31'h0, o[8]}, 32'h1);
    wrap_up();
  end
endmodule : breaker_transfer_sequencer_tb
`default_nettype wire
